// File: txcfg_pkg.sv
// constants for the serial-link transmitter analog configuration registers
// assumes a 32-bit apb slave port; every register is one aligned word
//
// Function
// - de-emphasis is thermometer code, fill from lsb
// - pll factor 00 is 20x, 10 is 40x
// - overrange select routes channel a flag to pin
// - routing needs select and override enable both
// - override enable replaces power-down pin function
// - three-bit swing picks one of eight amplitudes
package txcfg_pkg;

  // =========================================================
  // register index (printed offsets are not all multiples of four)
  localparam logic [7:0] idx_lane1_deemphasis_ctrl  = 8'h12;
  localparam logic [7:0] idx_lane0_deemphasis_ctrl  = 8'h13;
  localparam logic [7:0] idx_lane2_deemphasis_ctrl  = 8'h14;
  localparam logic [7:0] idx_lane3_deemphasis_ctrl  = 8'h15;
  localparam logic [7:0] idx_serializer_pll_factor  = 8'h16;
  localparam logic [7:0] idx_overrange_pin_select   = 8'h1a;
  localparam logic [7:0] idx_swing_and_pin_override = 8'h1b;
  // status register of the block's own state
  localparam logic [7:0] idx_txcfg_status           = 8'h1c;

  // =========================================================
  // field positions
  localparam int deemph_lsb   = 2;
  localparam int deemph_w     = 6;
  localparam int pll_lsb      = 0;
  localparam int pll_w        = 2;
  localparam int ovr_sel_bit  = 1;
  localparam int ovr_en_bit   = 3;
  localparam int swing_lsb    = 5;
  localparam int swing_w      = 3;

  // =========================================================
  // reset values and codes
  localparam logic [7:0] reg_reset_val = 8'h00;
  localparam logic [1:0] pll_code_20x  = 2'h0;
  localparam logic [1:0] pll_code_40x  = 2'h2;

endpackage : txcfg_pkg

// File: deemph_decode.sv
// thermometer check of one lane de-emphasis field
// assumes the field is a stored register value
`timescale 1ns/1ps
`default_nettype none
module deemph_decode
  import txcfg_pkg::*;
#(
  parameter int W = deemph_w
) (
  // field in
  input  wire logic [W-1:0] code,
  // decoded
  output logic              legal,
  output logic [$clog2(W+1)-1:0] level
);

  // legal when code+1 is a power of two, i.e. ones filled from lsb upward
  always_comb begin
    legal = ((code & (code + W'(1))) == '0);
    level = '0;
    for (int i = 0; i < W; i++) begin
      if (code[i]) begin
        level = level + 1'b1;
      end
    end
  end

endmodule : deemph_decode
`default_nettype wire

// File: txcfg_regs.sv
// apb register bank for transmitter de-emphasis, swing, pll factor and
// the power-down pin override
// assumes apb3 master on clk; power_down_pin_in is already synchronous
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module txcfg_regs
  import txcfg_pkg::*;
#(
  parameter int LANES = 4
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  // analog controls
  output logic [LANES*deemph_w-1:0]    lane_deemphasis,
  output logic [pll_w-1:0]             serializer_pll_factor,
  output logic                         pll_mode_40x,
  output logic [swing_w-1:0]           output_swing_select,
  // power-down pin path
  input  wire logic                    fast_overrange_flag,
  input  wire logic                    power_down_pin_in,
  output logic                         power_down_pin_out
);

  // =========================================================
  // apb decode
  logic [7:0]              idx;
  logic                    acc;
  logic                    wr;
  logic                    hit;
  logic [deemph_w-1:0]     deemph_r [LANES];
  logic [pll_w-1:0]        pll_r;
  logic                    ovr_sel_r;
  logic                    ovr_en_r;
  logic [swing_w-1:0]      swing_r;
  logic [LANES-1:0]        lane_legal;
  logic                    route_ovr;
  logic [7:0]              rd_byte;

  assign idx     = paddr[9:2];
  assign acc     = psel && penable;
  assign pready  = 1'b1;
  // a refused access (unmapped index or stray address bits) must not write
  assign wr      = acc && pwrite && hit;

  function automatic int lane_of(input logic [7:0] i);
    unique case (i)
      idx_lane0_deemphasis_ctrl: lane_of = 0;
      idx_lane1_deemphasis_ctrl: lane_of = 1;
      idx_lane2_deemphasis_ctrl: lane_of = 2;
      idx_lane3_deemphasis_ctrl: lane_of = 3;
      default:                   lane_of = -1;
    endcase
  endfunction : lane_of

  // =========================================================
  // storage; reserved bits are dropped on write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int l = 0; l < LANES; l++) begin
        deemph_r[l] <= reg_reset_val[deemph_w-1:0];
      end
    end else if (wr && lane_of(idx) >= 0 && lane_of(idx) < LANES) begin
      deemph_r[lane_of(idx)] <= pwdata[deemph_lsb +: deemph_w];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_r <= reg_reset_val[pll_w-1:0];
    end else if (wr && idx == idx_serializer_pll_factor) begin
      pll_r <= pwdata[pll_lsb +: pll_w];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_sel_r <= 1'b0;
    end else if (wr && idx == idx_overrange_pin_select) begin
      ovr_sel_r <= pwdata[ovr_sel_bit];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_en_r <= 1'b0;
      swing_r  <= reg_reset_val[swing_w-1:0];
    end else if (wr && idx == idx_swing_and_pin_override) begin
      ovr_en_r <= pwdata[ovr_en_bit];
      swing_r  <= pwdata[swing_lsb +: swing_w];
    end
  end

  // =========================================================
  // status: per-lane thermometer legality and pll code legality
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    deemph_decode #(.W(deemph_w)) u_dec (
      .code  (deemph_r[g]),
      .legal (lane_legal[g]),
      .level ()
    );
    assign lane_deemphasis[g*deemph_w +: deemph_w] = deemph_r[g];
  end

  assign serializer_pll_factor = pll_r;
  assign pll_mode_40x          = (pll_r == pll_code_40x);
  assign output_swing_select   = swing_r;

  // =========================================================
  // power-down pin override: both bits needed; a plain gate keeps the
  // overrange flag free of added latency
  assign route_ovr          = ovr_sel_r && ovr_en_r;
  assign power_down_pin_out = route_ovr ? fast_overrange_flag
                                        : power_down_pin_in;

  // =========================================================
  // read mux; reserved bits read zero
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    if (idx == idx_lane0_deemphasis_ctrl || idx == idx_lane1_deemphasis_ctrl ||
        idx == idx_lane2_deemphasis_ctrl || idx == idx_lane3_deemphasis_ctrl) begin
      if (lane_of(idx) < LANES) begin
        rd_byte[deemph_lsb +: deemph_w] = deemph_r[lane_of(idx)];
      end else begin
        hit = 1'b0;
      end
    end else if (idx == idx_serializer_pll_factor) begin
      rd_byte[pll_lsb +: pll_w] = pll_r;
    end else if (idx == idx_overrange_pin_select) begin
      rd_byte[ovr_sel_bit] = ovr_sel_r;
    end else if (idx == idx_swing_and_pin_override) begin
      rd_byte[swing_lsb +: swing_w] = swing_r;
      rd_byte[ovr_en_bit]           = ovr_en_r;
    end else if (idx == idx_txcfg_status) begin
      rd_byte[3:0] = 4'(lane_legal);
      rd_byte[4]   = (pll_r == pll_code_20x) || (pll_r == pll_code_40x);
      rd_byte[5]   = route_ovr;
    end else begin
      hit = 1'b0;
    end
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end
  end

  assign pslverr = acc && !hit;

  // read data registered during setup so it stands in the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // =========================================================
  // bus and write steps shared by the checks
  sequence s_setup_rd;
    psel && !penable && !pwrite;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  // read data is judged at the access edge that follows its setup
  sequence s_rd_xfer;
    s_setup_rd ##1 s_access;
  endsequence

  sequence s_lane0_wr;
    wr && idx == idx_lane0_deemphasis_ctrl;
  endsequence

  sequence s_lane1_wr;
    wr && idx == idx_lane1_deemphasis_ctrl;
  endsequence

  sequence s_lane2_wr;
    wr && idx == idx_lane2_deemphasis_ctrl;
  endsequence

  sequence s_lane3_wr;
    wr && idx == idx_lane3_deemphasis_ctrl;
  endsequence

  sequence s_pll_wr;
    wr && idx == idx_serializer_pll_factor;
  endsequence

  sequence s_sel_wr;
    wr && idx == idx_overrange_pin_select;
  endsequence

  sequence s_swing_wr;
    wr && idx == idx_swing_and_pin_override;
  endsequence

  // =========================================================
  // checks: power-down pin routing
  a_route_needs_both: assert property (@(posedge clk) disable iff (!rst_b)
    !(ovr_sel_r && ovr_en_r) |-> power_down_pin_out == power_down_pin_in)
    else $error("pin override active without both enables");
  a_route_flag_out: assert property (@(posedge clk) disable iff (!rst_b)
    (ovr_sel_r && ovr_en_r) |-> power_down_pin_out == fast_overrange_flag)
    else $error("overrange flag not on power-down pin");
  a_route_sel_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sel_wr ##0 !pwdata[ovr_sel_bit]) |=> power_down_pin_out == power_down_pin_in)
    else $error("pin still overridden after select cleared");
  a_route_en_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (s_swing_wr ##0 !pwdata[ovr_en_bit]) |=> power_down_pin_out == power_down_pin_in)
    else $error("pin still overridden after enable cleared");

  // checks: register writes land
  a_pll_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    s_pll_wr |=> pll_r == $past(pwdata[1:0]))
    else $error("pll factor write lost");
  a_pll_40x_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (s_pll_wr ##0 (pwdata[1:0] == pll_code_40x)) |=> pll_mode_40x)
    else $error("40x indication wrong");
  a_pll_20x_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (s_pll_wr ##0 (pwdata[1:0] == pll_code_20x)) |=> !pll_mode_40x)
    else $error("20x code shown as 40x");
  a_swing_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_swing_wr |=> swing_r == $past(pwdata[7:5]))
    else $error("swing write lost");
  a_ovren_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_swing_wr |=> ovr_en_r == $past(pwdata[3]))
    else $error("override enable write lost");
  a_lane0_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_lane0_wr |=> lane_deemphasis[5:0] == $past(pwdata[7:2]))
    else $error("lane0 de-emphasis write lost");
  a_lane1_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_lane1_wr |=> lane_deemphasis[11:6] == $past(pwdata[7:2]))
    else $error("lane1 de-emphasis write lost");
  a_lane2_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_lane2_wr |=> lane_deemphasis[17:12] == $past(pwdata[7:2]))
    else $error("lane2 de-emphasis write lost");
  a_lane3_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_lane3_wr |=> lane_deemphasis[23:18] == $past(pwdata[7:2]))
    else $error("lane3 de-emphasis write lost");
  a_lane_isolated: assert property (@(posedge clk) disable iff (!rst_b)
    s_lane0_wr |=> $stable(lane_deemphasis[11:6]))
    else $error("lane0 write disturbed lane1");
  a_sel_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_sel_wr |=> ovr_sel_r == $past(pwdata[1]))
    else $error("overrange select write lost");

  // checks: read data, refused accesses, thermometer status
  a_rd_upper_zero: assert property (@(posedge clk) disable iff (!rst_b)
    s_rd_xfer |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_pll_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_serializer_pll_factor && !pslverr)) |->
      prdata[7:0] == {6'h00, pll_r})
    else $error("pll factor reads back wrong");
  a_swing_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_swing_and_pin_override && !pslverr)) |->
      prdata[7:0] == {swing_r, 1'b0, ovr_en_r, 3'h0})
    else $error("swing register reads back wrong");
  a_sel_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_overrange_pin_select && !pslverr)) |->
      prdata[7:0] == {6'h00, ovr_sel_r, 1'b0})
    else $error("overrange select reads back wrong");
  a_lane0_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_lane0_deemphasis_ctrl && !pslverr)) |->
      prdata[7:0] == {lane_deemphasis[5:0], 2'b00})
    else $error("lane0 de-emphasis reads back wrong");
  a_lane1_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_lane1_deemphasis_ctrl && !pslverr)) |->
      prdata[7:0] == {lane_deemphasis[11:6], 2'b00})
    else $error("lane1 de-emphasis reads back wrong");
  a_lane2_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_lane2_deemphasis_ctrl && !pslverr)) |->
      prdata[7:0] == {lane_deemphasis[17:12], 2'b00})
    else $error("lane2 de-emphasis reads back wrong");
  a_lane3_readback: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_lane3_deemphasis_ctrl && !pslverr)) |->
      prdata[7:0] == {lane_deemphasis[23:18], 2'b00})
    else $error("lane3 de-emphasis reads back wrong");
  a_status_route: assert property (@(posedge clk) disable iff (!rst_b)
    (s_rd_xfer ##0 (idx == idx_txcfg_status && !pslverr)) |->
      prdata[5] == (ovr_sel_r && ovr_en_r))
    else $error("status routing bit wrong");
  a_refused_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    (s_access ##0 (pwrite && pslverr)) |=>
      ($stable(pll_r) && $stable(swing_r) && $stable(ovr_sel_r) && $stable(ovr_en_r)))
    else $error("refused write changed a register");
  a_therm_full: assert property (@(posedge clk) disable iff (!rst_b)
    (lane_deemphasis[23:18] == 6'h3f) |-> lane_legal[3])
    else $error("full de-emphasis code not seen as legal");
  a_therm_empty: assert property (@(posedge clk) disable iff (!rst_b)
    (lane_deemphasis[5:0] == 6'h00) |-> lane_legal[0])
    else $error("zero de-emphasis code not seen as legal");
  a_therm_gap: assert property (@(posedge clk) disable iff (!rst_b)
    (lane_deemphasis[5:0] == 6'h05) |-> !lane_legal[0])
    else $error("gapped de-emphasis code seen as legal");

endmodule : txcfg_regs
`default_nettype wire

// File: serdes_tx_analog_config_regs_bench.sv
// self-checking bench for the transmitter analog configuration register bank
// assumes txcfg_regs answers apb at once and routes the pin combinationally
`timescale 1ns/1ps
`default_nettype none
module serdes_tx_analog_config_regs_bench
  import txcfg_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, pll_mode_40x, power_down_pin_out;
  logic [23:0] lane_deemphasis;
  logic [1:0]  serializer_pll_factor;
  logic [2:0]  output_swing_select;
  logic        fast_overrange_flag = 1'b0, power_down_pin_in = 1'b0;
  int          bad_count = 0, samples_checked = 0;
  // lanes in order 0..3, then the rest of the bank except the status register
  localparam logic [7:0] regs_list [7] = '{idx_lane0_deemphasis_ctrl, idx_lane1_deemphasis_ctrl,
    idx_lane2_deemphasis_ctrl, idx_lane3_deemphasis_ctrl, idx_serializer_pll_factor,
    idx_overrange_pin_select, idx_swing_and_pin_override};
  localparam logic [5:0] therm [4] = '{6'h01, 6'h07, 6'h1f, 6'h3f};

  always #4 clk = ~clk;

  txcfg_regs #(.LANES(4)) i_txcfg_regs (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .lane_deemphasis(lane_deemphasis), .serializer_pll_factor(serializer_pll_factor),
    .pll_mode_40x(pll_mode_40x), .output_swing_select(output_swing_select),
    .fast_overrange_flag(fast_overrange_flag), .power_down_pin_in(power_down_pin_in),
    .power_down_pin_out(power_down_pin_out));

  // =========================================================
  // compare and bus tasks
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // holds the request until pready is seen high, then takes data and releases
  // lo carries paddr bits 11:10 and 1:0; any nonzero value is a refused access
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] lo,
                      input logic [31:0] d, input logic err, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {lo[3:2], idx, lo[1:0]};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    chk_pin(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, 4'h0, d, 1'b0, r);
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 4'h0, 32'h0, 1'b0, r);
    chk_data(r, exp);
  endtask : rd

  // =========================================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd(regs_list[i], 32'h0);
    rd(idx_txcfg_status, 32'h1f);
    chk_pin(power_down_pin_out, power_down_pin_in);
  endtask : t_reset

  // reserved bits set on purpose: they must read back as zero
  task automatic t_deemph;
    for (int l = 0; l < 4; l++) begin
      wr(regs_list[l], {24'hffffff, therm[l], 2'b11});
      chk_data(32'(lane_deemphasis[6*l +: 6]), 32'(therm[l]));
      rd(regs_list[l], {24'h0, therm[l], 2'b00});
    end
    rd(idx_txcfg_status, 32'h1f);
    wr(idx_lane0_deemphasis_ctrl, 32'h14);
    rd(idx_txcfg_status, 32'h1e);
  endtask : t_deemph

  task automatic t_pll;
    for (int c = 0; c < 4; c++) begin
      wr(idx_serializer_pll_factor, {24'h0, 6'h3f, 2'(c)});
      chk_data(32'(serializer_pll_factor), 32'(c));
      chk_pin(pll_mode_40x, 2'(c) == pll_code_40x);
      rd(idx_serializer_pll_factor, 32'(c));
      rd(idx_txcfg_status, {27'h0, c == 0 || c == 2, 4'he});
    end
  endtask : t_pll

  task automatic t_swing;
    for (int s = 0; s < 8; s++) begin
      wr(idx_swing_and_pin_override, {24'h0, 3'(s), 5'h17});
      chk_data(32'(output_swing_select), 32'(s));
      rd(idx_swing_and_pin_override, {24'h0, 3'(s), 5'h00});
    end
  endtask : t_swing

  // the pin follows the flag only while select and enable are both set
  task automatic t_override;
    logic sel, en;
    for (int k = 0; k < 4; k++) begin
      {sel, en} = 2'(k);
      wr(idx_overrange_pin_select, {24'h0, 6'h3f, sel, 1'b1});
      wr(idx_swing_and_pin_override, {24'h0, 3'h5, 1'b1, en, 3'h7});
      for (int f = 0; f < 2; f++) begin
        @(posedge clk);
        fast_overrange_flag <= f[0];
        power_down_pin_in <= ~f[0];
        @(negedge clk);
        chk_pin(power_down_pin_out, (sel & en) ? f[0] : ~f[0]);
      end
      rd(idx_txcfg_status, {26'h0, sel & en, 5'h0e});
    end
  endtask : t_override

  task automatic t_refused;
    logic [31:0] r;
    xfer(1'b1, 8'h17, 4'h0, 32'hff, 1'b1, r);
    xfer(1'b0, 8'h17, 4'h0, 32'h0, 1'b1, r);
    chk_data(r, 32'h0);
    xfer(1'b1, idx_serializer_pll_factor, 4'h1, 32'h1, 1'b1, r);
    xfer(1'b1, idx_serializer_pll_factor, 4'h4, 32'h0, 1'b1, r);
    rd(idx_serializer_pll_factor, 32'h3);
  endtask : t_refused

  // the digital-page lane mode decides which pll code software writes
  task automatic t_lane_mode;
    logic [7:0] mode;
    logic [1:0] code;
    for (int m = 1; m < 3; m++) begin
      mode = 8'(m);
      code = (mode == 8'h02) ? pll_code_40x : pll_code_20x;
      wr(idx_serializer_pll_factor, 32'(code));
      chk_pin(pll_mode_40x, mode == 8'h02);
      rd(idx_txcfg_status, 32'h3e);
    end
  endtask : t_lane_mode

  // a reset in mid-run clears every register and drops the pin override
  task automatic t_mid_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk_pin(power_down_pin_out, power_down_pin_in);
    t_reset();
  endtask : t_mid_reset

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // =========================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_deemph();
    t_pll();
    t_swing();
    t_override();
    t_refused();
    t_lane_mode();
    t_mid_reset();
    end_sim();
  end

  // the run needs a few hundred cycles; this leaves a wide margin
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end
endmodule : serdes_tx_analog_config_regs_bench
`default_nettype wire
